// >>> design/repeat_arith_sequencer.sv
// Repeat-mode sequencer for add, subtract, multiply and divide
`timescale 1ns/1ps
`include "arith_seq_params.svh"
module repeat_arith_sequencer #(
   parameter int AW = 11
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Scan tick, one cycle per program scan
   input wire logic scan_pulse_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Data register memory
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [AW-1:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_rdata_i,
   // Indicators
   output logic carry_borrow_flag_o,
   output logic execution_error_flag_o,
   output logic error_led_o,
   output logic irq_o
);
   generate
      if (AW < 9 || AW > 16) begin : g_bad_aw
         $error("operand_addr width AW must be 9 to 16");
      end
   endgenerate

   typedef struct packed {
      logic [15:0] ctrl;
      logic [AW-1:0] s1b;
      logic [AW-1:0] s2b;
      logic [AW-1:0] db;
      logic [2:0] imask;
      logic [2:0] istat;
      logic carry;
      logic err;
      arith_seq_pkg::state_t st;
      logic [15:0] cfg;
      logic [AW-1:0] c1;
      logic [AW-1:0] c2;
      logic [AW-1:0] cd;
      logic [6:0] iter;
      logic [1:0] wc;
      logic pend;
      logic [31:0] opa;
      logic [31:0] opb;
      logic [31:0] qv;
      logic [31:0] rv;
      logic cy_it;
      logic err_acc;
      logic mwe;
      logic [AW-1:0] maddr;
      logic [15:0] mwd;
      logic ack;
      logic [31:0] rdat;
   } st_t;

   st_t q;
   st_t d;

   // Latched instruction fields
   arith_seq_pkg::op_t op;
   arith_seq_pkg::dtype_t dt;
   logic [6:0] cnt;
   logic rep_s1, rep_s2, rep_d;
   logic [1:0] dw;
   logic [1:0] part_w;
   logic [2:0] total_w;
   logic part;
   logic [1:0] wj;
   logic [AW-1:0] rem_off;
   logic [AW-1:0] dextra;
   logic [15:0] wr_word;

   // Arithmetic results
   logic [31:0] a_quot, a_rem;
   logic a_carry, a_err;

   // Operand address generation
   logic [AW-1:0] op_base [3];
   logic op_rep [3];
   logic [1:0] op_stride [3];
   logic [AW-1:0] op_extra [3];
   logic [AW-1:0] op_addr [3];

   // Bus decode
   logic bus_req;
   logic wr_en;
   logic [2:0] ridx;
   logic [31:0] wmask;
   logic [2:0] stat_clr, stat_set;
   logic err_clr;
   logic start;
   logic [6:0] ctrl_cnt;

   always_comb begin
      op = arith_seq_pkg::op_t'(q.cfg[`CTRL_OP_HI:`CTRL_OP_LO]);
      dt = arith_seq_pkg::dtype_t'(q.cfg[`CTRL_DT_HI:`CTRL_DT_LO]);
      cnt = q.cfg[`CTRL_CNT_HI:`CTRL_CNT_LO];
      rep_s1 = q.cfg[`CTRL_RS1];
      rep_s2 = q.cfg[`CTRL_RS2];
      rep_d = q.cfg[`CTRL_RD];
      // One word for 16-bit types, a pair for 32-bit types
      dw = (dt == arith_seq_pkg::DT_WORD || dt == arith_seq_pkg::DT_INT) ?
           2'h1 : 2'h2;
      // Multiply always produces a word pair
      part_w = (op == arith_seq_pkg::OP_MUL) ? 2'h2 : dw;
      // Integer divide adds a remainder part, float divide does not
      total_w = (op == arith_seq_pkg::OP_DIV &&
                 dt != arith_seq_pkg::DT_FLOAT) ?
                3'({part_w, 1'b0}) : 3'(part_w);
      part = 3'(q.wc) >= 3'(part_w);
      wj = part ? 2'(q.wc - part_w) : q.wc;
      // Remainders follow the whole quotient run or the single quotient
      rem_off = rep_d ? AW'(cnt) * AW'(part_w) : AW'(part_w);
      dextra = AW'(wj) + (part ? rem_off : AW'(0));
      if (part_w == 2'h2) begin
         wr_word = part ? (wj == 2'h0 ? q.rv[31:16] : q.rv[15:0])
                        : (wj == 2'h0 ? q.qv[31:16] : q.qv[15:0]);
      end else begin
         wr_word = part ? q.rv[15:0] : q.qv[15:0];
      end
      op_base[0] = q.c1;
      op_base[1] = q.c2;
      op_base[2] = q.cd;
      op_rep[0] = rep_s1;
      op_rep[1] = rep_s2;
      op_rep[2] = rep_d;
      op_stride[0] = dw;
      op_stride[1] = dw;
      op_stride[2] = part_w;
      op_extra[0] = AW'(q.wc);
      op_extra[1] = AW'(q.wc);
      op_extra[2] = dextra;
   end

   generate
      for (genvar g = 0; g < 3; g++) begin : g_addr
         operand_addr #(
            .AW(AW)
         ) u_addr (
            .base_i(op_base[g]),
            .rep_i(op_rep[g]),
            .iter_i(q.iter),
            .stride_i(op_stride[g]),
            .extra_i(op_extra[g]),
            .addr_o(op_addr[g])
         );
      end
   endgenerate

   arith_unit u_alu (
      .op_i(op),
      .dt_i(dt),
      .a_i(q.opa),
      .b_i(q.opb),
      .quot_o(a_quot),
      .rem_o(a_rem),
      .carry_o(a_carry),
      .err_o(a_err)
   );

   always_comb begin
      d = q;
      bus_req = wb_cyc_i && wb_stb_i && !q.ack;
      wr_en = bus_req && wb_we_i;
      ridx = wb_adr_i[4:2];
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      stat_set = 3'h0;
      stat_clr = 3'h0;
      err_clr = 1'b0;
      ctrl_cnt = 7'h00;
      start = 1'b0;

      // Wishbone: answer one cycle after the strobe, drop ack next cycle
      d.ack = bus_req;
      if (bus_req) begin
         case (ridx)
            `RA_CTRL: d.rdat = {16'h0000, q.ctrl};
            `RA_S1_BASE: d.rdat = 32'(q.s1b);
            `RA_S2_BASE: d.rdat = 32'(q.s2b);
            `RA_D_BASE: d.rdat = 32'(q.db);
            `RA_FLAGS: d.rdat = 32'({q.st != arith_seq_pkg::ST_IDLE,
                                     q.err, q.carry});
            `RA_IRQ_STAT: d.rdat = 32'(q.istat);
            `RA_IRQ_MASK: d.rdat = 32'(q.imask);
            default: d.rdat = 32'h00000000;
         endcase
      end
      if (wr_en) begin
         case (ridx)
            `RA_CTRL: d.ctrl = 16'((q.ctrl & ~wmask[15:0]) |
                                   (wb_dat_i[15:0] & wmask[15:0]));
            `RA_S1_BASE: d.s1b = AW'((32'(q.s1b) & ~wmask) |
                                     (wb_dat_i & wmask));
            `RA_S2_BASE: d.s2b = AW'((32'(q.s2b) & ~wmask) |
                                     (wb_dat_i & wmask));
            `RA_D_BASE: d.db = AW'((32'(q.db) & ~wmask) |
                                   (wb_dat_i & wmask));
            `RA_FLAGS: err_clr = wb_dat_i[`FLG_ERR] && wb_sel_i[0];
            `RA_IRQ_STAT: stat_clr = wb_dat_i[2:0] & {3{wb_sel_i[0]}};
            `RA_IRQ_MASK: begin
               if (wb_sel_i[0]) d.imask = wb_dat_i[2:0];
            end
            default: ;
         endcase
      end

      // Sequencer
      case (q.st)
         arith_seq_pkg::ST_IDLE: begin
            // Runs once per scan while the condition bit is on
            if (scan_pulse_i && q.ctrl[`CTRL_COND]) begin
               start = 1'b1;
               d.cfg = q.ctrl;
               d.c1 = q.s1b;
               d.c2 = q.s2b;
               d.cd = q.db;
               d.iter = 7'h00;
               d.wc = 2'h0;
               d.pend = 1'b0;
               d.err_acc = 1'b0;
               d.cy_it = 1'b0;
               ctrl_cnt = q.ctrl[`CTRL_CNT_HI:`CTRL_CNT_LO];
               if (ctrl_cnt < `REP_MIN || ctrl_cnt > `REP_MAX) begin
                  // Illegal count: flag an error; counts 0 and 100 touch no memory, 101 and up still run iterations 100 onward
                  d.err_acc = 1'b1;
                  d.st = arith_seq_pkg::ST_STEP;
                  d.iter = `REP_MAX;
               end else begin
                  d.st = arith_seq_pkg::ST_RD_A;
               end
            end
         end
         arith_seq_pkg::ST_RD_A, arith_seq_pkg::ST_RD_B: begin
            if (!q.pend) begin
               d.pend = 1'b1;
               d.mwe = 1'b0;
               d.maddr = (q.st == arith_seq_pkg::ST_RD_A) ?
                         op_addr[0] : op_addr[1];
            end else if (mem_ack_i) begin
               d.pend = 1'b0;
               // First word of a pair is the upper half
               if (q.st == arith_seq_pkg::ST_RD_A) begin
                  if (dw == 2'h2 && q.wc == 2'h0) d.opa[31:16] = mem_rdata_i;
                  else d.opa[15:0] = mem_rdata_i;
               end else begin
                  if (dw == 2'h2 && q.wc == 2'h0) d.opb[31:16] = mem_rdata_i;
                  else d.opb[15:0] = mem_rdata_i;
               end
               if (q.wc + 2'h1 < dw) begin
                  d.wc = q.wc + 2'h1;
               end else begin
                  d.wc = 2'h0;
                  d.st = (q.st == arith_seq_pkg::ST_RD_A) ?
                         arith_seq_pkg::ST_RD_B : arith_seq_pkg::ST_CALC;
               end
            end
         end
         arith_seq_pkg::ST_CALC: begin
            d.qv = a_quot;
            d.rv = a_rem;
            // Each iteration overwrites, so the last one decides
            d.cy_it = a_carry;
            d.err_acc = q.err_acc || a_err;
            d.wc = 2'h0;
            // A failed iteration leaves its destination untouched
            d.st = a_err ? arith_seq_pkg::ST_STEP : arith_seq_pkg::ST_WR;
         end
         arith_seq_pkg::ST_WR: begin
            if (!q.pend) begin
               d.pend = 1'b1;
               d.mwe = 1'b1;
               // Destination steps with the iteration when rep_d is set; otherwise each iteration overwrites the same slot
               d.maddr = op_addr[2];
               d.mwd = wr_word;
            end else if (mem_ack_i) begin
               d.pend = 1'b0;
               d.mwe = 1'b0;
               if (3'(q.wc) + 3'h1 < total_w) begin
                  d.wc = q.wc + 2'h1;
               end else begin
                  d.wc = 2'h0;
                  d.st = arith_seq_pkg::ST_STEP;
               end
            end
         end
         arith_seq_pkg::ST_STEP: begin
            // Ascending iteration index; kth operands meet in iteration k
            if (q.iter + 7'h01 < cnt) begin
               d.iter = q.iter + 7'h01;
               d.st = arith_seq_pkg::ST_RD_A;
            end else begin
               d.carry = q.cy_it;
               stat_set[`IRQ_DONE] = 1'b1;
               stat_set[`IRQ_ERR] = q.err_acc;
               stat_set[`IRQ_CARRY] = q.cy_it;
               d.st = arith_seq_pkg::ST_IDLE;
            end
         end
         default: d.st = arith_seq_pkg::ST_IDLE;
      endcase

      // Sticky flags: a new event wins over a clear in the same cycle
      d.err = (q.err && !err_clr) || stat_set[`IRQ_ERR];
      d.istat = (q.istat & ~stat_clr) | stat_set;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         q <= '0;
         q.ctrl <= `CTRL_RST;
         q.cfg <= `CTRL_RST;
         q.st <= arith_seq_pkg::ST_IDLE;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign mem_req_o = q.pend;
   assign mem_we_o = q.mwe;
   assign mem_addr_o = q.maddr;
   assign mem_wdata_o = q.mwd;
   assign carry_borrow_flag_o = q.carry;
   assign execution_error_flag_o = q.err;
   assign error_led_o = q.err;
   assign irq_o = |(q.istat & q.imask);
endmodule

// >>> design/arith_seq_params.svh
// Register map, field positions and limits of the repeat arithmetic sequencer
`ifndef ARITH_SEQ_PARAMS_SVH
`define ARITH_SEQ_PARAMS_SVH

// Word index of each register; byte address is index times four
`define RA_CTRL 3'h0
`define RA_S1_BASE 3'h1
`define RA_S2_BASE 3'h2
`define RA_D_BASE 3'h3
`define RA_FLAGS 3'h4
`define RA_IRQ_STAT 3'h5
`define RA_IRQ_MASK 3'h6

// Control register fields
`define CTRL_COND 0
`define CTRL_RS1 1
`define CTRL_RS2 2
`define CTRL_RD 3
`define CTRL_OP_LO 4
`define CTRL_OP_HI 5
`define CTRL_DT_LO 6
`define CTRL_DT_HI 8
`define CTRL_CNT_LO 9
`define CTRL_CNT_HI 15
`define CTRL_RST 16'h0200

// Flag register and interrupt bits
`define FLG_CARRY 0
`define FLG_ERR 1
`define FLG_BUSY 2
`define IRQ_DONE 0
`define IRQ_ERR 1
`define IRQ_CARRY 2

// Repeat count limits
`define REP_MIN 7'h01
`define REP_MAX 7'h63

// Data type ranges
`define LIM_W_MAX 68'sh0_0000_0000_0000_FFFF
`define LIM_I_MIN -68'sh0_0000_0000_0000_8000
`define LIM_I_MAX 68'sh0_0000_0000_0000_7FFF
`define LIM_D_MAX 68'sh0_0000_0000_FFFF_FFFF
`define LIM_L_MIN -68'sh0_0000_0000_8000_0000
`define LIM_L_MAX 68'sh0_0000_0000_7FFF_FFFF
`define FLT_EXP_MAX 8'hFF

`endif

// >>> design/arith_seq_pkg.sv
// Types shared by the repeat arithmetic sequencer
package arith_seq_pkg;
   typedef enum logic [1:0] {
      OP_ADD = 2'h0,
      OP_SUB = 2'h1,
      OP_MUL = 2'h2,
      OP_DIV = 2'h3
   } op_t;
   typedef enum logic [2:0] {
      DT_WORD = 3'h0,
      DT_INT = 3'h1,
      DT_DWORD = 3'h2,
      DT_LONG = 3'h3,
      DT_FLOAT = 3'h4
   } dtype_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RD_A = 6'h02,
      ST_RD_B = 6'h04,
      ST_CALC = 6'h08,
      ST_WR = 6'h10,
      ST_STEP = 6'h20
   } state_t;
endpackage

// >>> design/operand_addr.sv
// Operand word address: base plus iteration stride plus word offset
`timescale 1ns/1ps
module operand_addr #(
   parameter int AW = 11
) (
   // Operand description
   input wire logic [AW-1:0] base_i,
   input wire logic rep_i,
   input wire logic [6:0] iter_i,
   input wire logic [1:0] stride_i,
   input wire logic [AW-1:0] extra_i,
   // Resulting address
   output logic [AW-1:0] addr_o
);
   logic [8:0] step;
   always_comb begin
      step = rep_i ? 9'(iter_i) * 9'(stride_i) : 9'h000;
      addr_o = AW'(base_i + AW'(step) + extra_i);
   end
endmodule

// >>> design/arith_unit.sv
// Combinational add, subtract, multiply and divide with range checks
`timescale 1ns/1ps
`include "arith_seq_params.svh"
module arith_unit (
   // Operation select
   input arith_seq_pkg::op_t op_i,
   input arith_seq_pkg::dtype_t dt_i,
   // Operands
   input wire logic [31:0] a_i,
   input wire logic [31:0] b_i,
   // Results
   output logic [31:0] quot_o,
   output logic [31:0] rem_o,
   output logic carry_o,
   output logic err_o
);
   logic is32;
   logic sgn;
   logic signed [33:0] ax, bx, bd, quo, rmd;
   logic signed [67:0] r;

   function automatic logic signed [33:0] ext(input logic [31:0] v,
                                              input logic w, input logic s);
      if (w) ext = s ? {{2{v[31]}}, v} : {2'b00, v};
      else ext = s ? {{18{v[15]}}, v[15:0]} : {18'h00000, v[15:0]};
   endfunction

   function automatic logic oor(input logic signed [67:0] v,
                                input arith_seq_pkg::dtype_t t);
      case (t)
         arith_seq_pkg::DT_WORD: oor = v < 0 || v > `LIM_W_MAX;
         arith_seq_pkg::DT_INT: oor = v < `LIM_I_MIN || v > `LIM_I_MAX;
         arith_seq_pkg::DT_DWORD: oor = v < 0 || v > `LIM_D_MAX;
         arith_seq_pkg::DT_LONG: oor = v < `LIM_L_MIN || v > `LIM_L_MAX;
         default: oor = 1'b0;
      endcase
   endfunction

   function automatic logic abnormal(input logic [31:0] v);
      abnormal = v[30:23] == `FLT_EXP_MAX ||
                 (v[30:23] == 8'h00 && v[22:0] != 23'h000000);
   endfunction

   always_comb begin
      is32 = dt_i != arith_seq_pkg::DT_WORD && dt_i != arith_seq_pkg::DT_INT;
      sgn = dt_i == arith_seq_pkg::DT_INT || dt_i == arith_seq_pkg::DT_LONG;
      ax = ext(a_i, is32, sgn);
      bx = ext(b_i, is32, sgn);
      bd = (bx == 34'sh0) ? 34'sh1 : bx;
      quo = ax / bd;
      rmd = ax % bd;
      case (op_i)
         arith_seq_pkg::OP_ADD: r = 68'(ax + bx);
         arith_seq_pkg::OP_SUB: r = 68'(ax - bx);
         arith_seq_pkg::OP_MUL: r = 68'(ax) * 68'(bx);
         default: r = 68'(quo);
      endcase
      quot_o = r[31:0];
      rem_o = rmd[31:0];
      // Full 16-bit product always fits its word pair
      carry_o = op_i != arith_seq_pkg::OP_DIV &&
                !(op_i == arith_seq_pkg::OP_MUL && !is32) &&
                oor(r, dt_i);
      err_o = op_i == arith_seq_pkg::OP_DIV &&
              (bx == 34'sh0 || (sgn && oor(r, dt_i)));
      if (dt_i == arith_seq_pkg::DT_FLOAT) begin
         // No float core here: format is checked, result reads as zero
         quot_o = 32'h00000000;
         rem_o = 32'h00000000;
         carry_o = 1'b0;
         err_o = abnormal(a_i) || abnormal(b_i) ||
                 (op_i == arith_seq_pkg::OP_DIV && b_i[30:0] == 31'h0);
      end
   end
endmodule

// >>> sim/rep_seq_checker.sv
// Port assertions for the repeat arithmetic sequencer
`timescale 1ns/1ps
module rep_seq_checker #(
   parameter int AW = 11
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic wb_ack_o,
   // Memory port
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [AW-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   // Indicators
   input wire logic carry_borrow_flag_o,
   input wire logic execution_error_flag_o,
   input wire logic error_led_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("no ack");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   // Error flag may only drop on a write to the flag register
   property p_err_sticky;
      execution_error_flag_o && !(wb_stb_i && wb_we_i && wb_adr_i[4:2] == 3'h4)
         |=> execution_error_flag_o;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error lost");
   property p_led_eq;
      error_led_o == execution_error_flag_o;
   endproperty
   a_led_eq: assert property (p_led_eq) else $error("led differs");
   property p_req_hold;
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
         && $stable(mem_we_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   property p_req_drop;
      mem_req_o && mem_ack_i |=> !mem_req_o;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request kept");
   // Carry only moves once the run is over
   property p_carry_quiet;
      mem_req_o && !mem_ack_i |=> $stable(carry_borrow_flag_o);
   endproperty
   a_carry_quiet: assert property (p_carry_quiet) else $error("carry moved");
   c_write: cover property (mem_req_o && mem_we_o && mem_ack_i);
   c_err: cover property ($rose(execution_error_flag_o));
   c_carry: cover property ($rose(carry_borrow_flag_o));
endmodule
bind repeat_arith_sequencer rep_seq_checker #(.AW(AW)) chk (.ref_clk_i,
   .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
   .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i, .carry_borrow_flag_o,
   .execution_error_flag_o, .error_led_o);

// >>> sim/data_mem_model.sv
// Data register memory answering the sequencer's word requests
`timescale 1ns/1ps
module data_mem_model #(
   parameter int AW = 11
) (
   // Clock and answer delay
   input wire logic clk_i,
   input wire logic [3:0] lat_i,
   // Request
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   // Answer
   output logic ack_o,
   output logic [15:0] rdata_o
);
   logic [15:0] mem [0:(1<<AW)-1];
   logic [15:0] last_q = 16'h0000;
   logic [3:0] wait_q = 4'h0;
   initial ack_o = 1'b0;
   initial rdata_o = 16'h0000;
   // Read data is only valid with ack; otherwise it shows a wrong value
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~last_q;
      if (req_i && !ack_o) begin
         if (wait_q < lat_i) begin
            wait_q <= wait_q + 4'h1;
         end else begin
            wait_q <= 4'h0;
            ack_o <= 1'b1;
            if (we_i) begin
               mem[addr_i] <= wdata_i;
            end else begin
               rdata_o <= mem[addr_i];
               last_q <= mem[addr_i];
            end
         end
      end
   end
endmodule

// >>> sim/repeat_arith_sequencer_tb.sv
// Self-checking bench for the repeat arithmetic sequencer
`timescale 1ns/1ps
module repeat_arith_sequencer_tb;
   logic clk = 1'b0, rst_n = 1'b0, scan = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic we = 1'b0, ack, req, mwe, mack, cy, err, led, irq;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hF, lat = 4'h2;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [10:0] maddr;
   logic [15:0] mwd, mrd;
   int failures = 0, tests_run = 0;
   always #2 clk = ~clk;
   repeat_arith_sequencer dut (.ref_clk_i(clk), .reset_n_i(rst_n),
      .scan_pulse_i(scan), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .mem_req_o(req), .mem_we_o(mwe), .mem_addr_o(maddr),
      .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd),
      .carry_borrow_flag_o(cy), .execution_error_flag_o(err),
      .error_led_o(led), .irq_o(irq));
   data_mem_model mdl (.clk_i(clk), .lat_i(lat), .req_i(req), .we_i(mwe),
      .addr_i(maddr), .wdata_i(mwd), .ack_o(mack), .rdata_o(mrd));
   task automatic final_report();
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_mem(input int a, input logic [15:0] e);
      tests_run++;
      if (mdl.mem[a] !== e) begin
         failures++;
         $display("[ERR] mem %0h exp %h got %h", a, e, mdl.mem[a]);
      end
   endtask
   // One classic cycle; read data lands in q
   task automatic bus(input logic w, input logic [2:0] i, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      if (ack !== 1'b1) failures++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic pulse();
      @(posedge clk);
      scan <= 1'b1;
      @(posedge clk);
      scan <= 1'b0;
   endtask
   task automatic put3(input int a, input logic [15:0] x, y, z);
      mdl.mem[a] = x;
      mdl.mem[a+1] = y;
      mdl.mem[a+2] = z;
   endtask
   // Configure, start one scan and wait until busy clears
   task automatic run(input logic [1:0] op, input logic [2:0] dt,
         input logic [2:0] rep, input logic [6:0] cnt,
         input logic [10:0] s1, s2, d);
      int n;
      bus(1'b1, 3'h1, {21'h0, s1});
      bus(1'b1, 3'h2, {21'h0, s2});
      bus(1'b1, 3'h3, {21'h0, d});
      bus(1'b1, 3'h0, {16'h0, cnt, dt, op, rep, 1'b1});
      pulse();
      n = 0;
      q = 32'h4;
      while (q[2] !== 1'b0 && n < 200) begin
         bus(1'b0, 3'h4, 32'h0);
         n++;
      end
      if (q[2] !== 1'b0) failures++;
   endtask
   initial begin
      #100000;
      failures++;
      final_report();
   end
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mdl.mem[i] = 16'hAAAA;
      end
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 3'h0, 32'h0);
      chk_reg("ctrl", 32'h0000_0200, q);
      bus(1'b0, 3'h7, 32'h0);
      chk_reg("unmapped", 32'h0, q);
      bus(1'b1, 3'h0, 32'h0000_0208);
      pulse();
      repeat (20) @(posedge clk);
      chk_mem(11'h030, 16'hAAAA);
      put3(11'h010, 16'h0005, 16'h0001, 16'h0002);
      mdl.mem[11'h020] = 16'h0007;
      run(arith_seq_pkg::OP_ADD, arith_seq_pkg::DT_WORD, 3'h4, 7'h03,
         11'h010, 11'h020, 11'h030);
      for (int k = 0; k < 3; k++) chk_mem(11'h030 + k, 16'h000C);
      chk_mem(11'h033, 16'hAAAA);
      run(arith_seq_pkg::OP_ADD, arith_seq_pkg::DT_WORD, 3'h5, 7'h03,
         11'h010, 11'h020, 11'h040);
      for (int k = 0; k < 3; k++) begin
         chk_mem(11'h040 + k, 16'(k == 0 ? 12 : 7 + k));
      end
      put3(11'h014, 16'hFFFF, 16'h0001, 16'h0002);
      put3(11'h017, 16'h0001, 16'h0001, 16'h0001);
      run(arith_seq_pkg::OP_ADD, arith_seq_pkg::DT_WORD, 3'h3, 7'h03,
         11'h014, 11'h017, 11'h050);
      chk_mem(11'h050, 16'h0003);
      chk_mem(11'h051, 16'hAAAA);
      chk_reg("carry", 32'h0, {31'h0, cy});
      put3(11'h014, 16'h0005, 16'h0006, 16'h0000);
      run(arith_seq_pkg::OP_SUB, arith_seq_pkg::DT_WORD, 3'h7, 7'h03,
         11'h014, 11'h017, 11'h060);
      chk_mem(11'h061, 16'h0005);
      chk_reg("borrow", 32'h1, {31'h0, cy});
      chk_reg("flags", 32'h1, q);
      put3(11'h01A, 16'h7FFF, 16'h0001, 16'h0000);
      run(arith_seq_pkg::OP_ADD, arith_seq_pkg::DT_INT, 3'h0, 7'h01,
         11'h01A, 11'h01B, 11'h064);
      chk_reg("int carry", 32'h1, {31'h0, cy});
      put3(11'h0A0, 16'h0001, 16'h0000, 16'h0002);
      put3(11'h0A3, 16'h0000, 16'h0000, 16'h0005);
      lat <= 4'h0;
      for (int j = 0; j < 2; j++) begin
         run(arith_seq_pkg::OP_ADD, j ? arith_seq_pkg::DT_LONG :
            arith_seq_pkg::DT_DWORD, 3'h5, 7'h02, 11'h0A0, 11'h0A4, 11'h070 + 8 * j);
         chk_mem(11'h071 + 8 * j, 16'h0005);
         chk_mem(11'h072 + 8 * j, 16'h0002);
         chk_mem(11'h074 + 8 * j, 16'hAAAA);
      end
      put3(11'h0B0, 16'h0100, 16'h0200, 16'h0300);
      run(arith_seq_pkg::OP_MUL, arith_seq_pkg::DT_WORD, 3'h1, 7'h02,
         11'h0B0, 11'h0B2, 11'h080);
      chk_mem(11'h080, 16'h0006);
      chk_mem(11'h081, 16'h0000);
      put3(11'h0B3, 16'h0002, 16'h0003, 16'h0000);
      run(arith_seq_pkg::OP_MUL, arith_seq_pkg::DT_WORD, 3'h4, 7'h02,
         11'h0B3, 11'h0B4, 11'h084);
      chk_mem(11'h085, 16'h0006);
      chk_mem(11'h087, 16'h0006);
      put3(11'h0B6, 16'h0014, 16'h0011, 16'h0005);
      run(arith_seq_pkg::OP_DIV, arith_seq_pkg::DT_WORD, 3'h1, 7'h02,
         11'h0B6, 11'h0B8, 11'h090);
      chk_mem(11'h090, 16'h0003);
      chk_mem(11'h091, 16'h0002);
      run(arith_seq_pkg::OP_DIV, arith_seq_pkg::DT_WORD, 3'h4, 7'h02,
         11'h0B7, 11'h0B8, 11'h0D0);
      chk_mem(11'h0D1, 16'h0003);
      chk_mem(11'h0D3, 16'h0002);
      chk_mem(11'h0D4, 16'hAAAA);
      put3(11'h0C0, 16'h3F80, 16'h0000, 16'h0000);
      run(arith_seq_pkg::OP_DIV, arith_seq_pkg::DT_FLOAT, 3'h4, 7'h02,
         11'h0C0, 11'h0C0, 11'h098);
      chk_mem(11'h09B, 16'h0000);
      chk_mem(11'h09C, 16'hAAAA);
      bus(1'b1, 3'h6, 32'h2);
      run(arith_seq_pkg::OP_DIV, arith_seq_pkg::DT_WORD, 3'h0, 7'h01,
         11'h0B6, 11'h0C2, 11'h0A8);
      chk_reg("err", 32'h7, {29'h0, led, err, irq});
      run(arith_seq_pkg::OP_ADD, arith_seq_pkg::DT_WORD, 3'h0, 7'h01,
         11'h010, 11'h020, 11'h0AA);
      chk_mem(11'h0AA, 16'h000C);
      chk_reg("err held", 32'h1, {31'h0, err});
      bus(1'b1, 3'h4, 32'h2);
      bus(1'b1, 3'h5, 32'h7);
      chk_reg("cleared", 32'h0, {30'h0, err, irq});
      for (int j = 0; j < 2; j++) begin
         run(arith_seq_pkg::OP_ADD, arith_seq_pkg::DT_WORD, 3'h4,
            j ? 7'h64 : 7'h00, 11'h010, 11'h020, 11'h0B9);
         chk_reg("count", 32'h1, {31'h0, err});
         chk_mem(11'h0B9, 16'hAAAA);
         bus(1'b1, 3'h4, 32'h2);
      end
      bus(1'b0, 3'h3, 32'h0);
      chk_reg("dbase", 32'h0B9, q);
      bus(1'b1, 3'h6, 32'h1);
      bus(1'b0, 3'h6, 32'h0);
      chk_reg("mask", 32'h1, q);
      chk_reg("done irq", 32'h1, {31'h0, irq});
      bus(1'b1, 3'h5, 32'h1);
      chk_reg("irq off", 32'h0, {31'h0, irq});
      final_report();
   end
endmodule
